// ---- rtl/ddo_regs.svh ----
`ifndef DDO_REGS_SVH
`define DDO_REGS_SVH

// ----------------------------------------
// Line and address geometry
// ----------------------------------------
`define DDO_ADDR_W        32
`define DDO_LINE_OFS_W    6
`define DDO_CHAN_DATA_W   64
`define DDO_ROW_W_MAX     14
`define DDO_COL_W         10
`define DDO_BANK_W_MAX    3
`define DDO_LINE_BYTES    64

// ----------------------------------------
// Rank capacity encodings, in 64-byte lines
// ----------------------------------------
// 256 MB = 2^22 lines, 512 MB = 2^23, 1 GB = 2^24
`define DDO_LINES_256M    32'h0040_0000
`define DDO_LINES_512M    32'h0080_0000
`define DDO_LINES_1G      32'h0100_0000

// ----------------------------------------
// Module type codes
// ----------------------------------------
`define DDO_MOD_SS_X16    2'h0
`define DDO_MOD_SS_X8     2'h1
`define DDO_MOD_DS_X8     2'h2

// ----------------------------------------
// Decode field widths
// ----------------------------------------
`define DDO_ROW_X16       4'hd
`define DDO_ROW_X8        4'he
`define DDO_BANKS_512M    2'h2
`define DDO_BANKS_1G      2'h3
`define DDO_PAGE_BYTES    16'h2000

`endif

// ---- rtl/ddo_pkg.sv ----
package ddo_pkg;

    typedef enum logic [2:0] {
        DDO_ORG_NONE = 3'b000,
        DDO_ORG_SINGLE = 3'b001,
        DDO_ORG_SYM = 3'b010,
        DDO_ORG_ASYM = 3'b100
    } ddo_org_e;

    typedef enum logic [2:0] {
        DDO_CH_IDLE = 3'b001,
        DDO_CH_BUSY = 3'b010,
        DDO_CH_DONE = 3'b100
    } ddo_chst_e;

    // Population of one channel, one DIMM at most
    typedef struct packed {
        logic       present;
        logic [1:0] modType;
        logic       gigabit;
    } ddo_dimm_s;

    // Host cache-line request
    typedef struct packed {
        logic        write;
        logic [25:0] line;
        logic [3:0]  tag;
    } ddo_req_s;

    // Per-channel DRAM address
    typedef struct packed {
        logic        write;
        logic        rank;
        logic [2:0]  bank;
        logic [13:0] row;
        logic [9:0]  col;
        logic [3:0]  tag;
    } ddo_cmd_s;

endpackage : ddo_pkg

// ---- rtl/ddo_organizer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ddo_regs.svh"

// Notes on behaviour
// [RULE1] Two independent 64-bit DDR2 channels, one DIMM each.
// [RULE2] One unbuffered non-ECC DIMM per channel; no check bits handled.
// [RULE3] Requests are whole 64-byte cache lines.
// [RULE4] Single organization sends every cycle to the populated channel.
// [RULE5] Single chosen when only one channel, either one, is populated.
// [RULE6] Symmetric organization alternates channels every 64-byte line.
// [RULE7] Request to idle opposite channel issues before first data returns.
// [RULE8] Symmetric: two consecutive lines fetched at once, one per channel.
// [RULE9] Symmetric chosen for equal capacities, whatever device type or width.
// [RULE10] Asymmetric fills channel 0 fully, then channel 1 from bottom.
// [RULE11] Asymmetric chosen when both populated with different capacity.
// [RULE12] Interface runs at 667 or 800 transfers per pin rates.
// [RULE13] 512 megabit and 1 gigabit device densities supported.
// [RULE14] Single-sided x16, single-sided x8, double-sided x8 modules supported.
// [RULE15] Decode 13/10 or 14/10 row/col, 4 or 8 banks, 8K page.
// [RULE16] Symmetric channel bit is lowest line address bit above offset.
module ddo_organizer #(
    parameter int LINE_W = 26
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    input  wire logic             clkEn,
    // Population straps and rate select
    input  wire ddo_pkg::ddo_dimm_s dimm0,
    input  wire ddo_pkg::ddo_dimm_s dimm1,
    input  wire logic             rate800,
    input  wire logic             cfgLoad,
    // Host request side
    input  wire logic             reqValid,
    input  wire ddo_pkg::ddo_req_s  req,
    output logic                  reqReady,
    output logic                  reqErr,
    // Channel command side
    output logic [1:0]            chCmdValid,
    output ddo_pkg::ddo_cmd_s       chCmd0,
    output ddo_pkg::ddo_cmd_s       chCmd1,
    input  wire logic [1:0]       chCmdReady,
    input  wire logic [1:0]       chDone,
    // Status
    output ddo_pkg::ddo_org_e       org,
    output logic                  rateIs800,
    output logic [1:0]            chBusy
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Capacity of one DIMM in cache lines
    function automatic logic [31:0] dimmLines(input ddo_pkg::ddo_dimm_s d);
        logic [31:0] r;
        r = 32'h0;
        if (d.present) begin
            case (d.modType)
                `DDO_MOD_SS_X16: r = d.gigabit ? `DDO_LINES_512M : `DDO_LINES_256M;
                `DDO_MOD_SS_X8: r = d.gigabit ? `DDO_LINES_1G : `DDO_LINES_512M;
                `DDO_MOD_DS_X8: r = d.gigabit ? (`DDO_LINES_1G << 1) : `DDO_LINES_1G;
                default: r = 32'h0; // Unsupported module left unused, see [RULE14]
            endcase
        end
        return r;
    endfunction : dimmLines

    // Split a channel-local line index into rank, bank, row, col (see [RULE15])
    function automatic ddo_pkg::ddo_cmd_s decode(input ddo_pkg::ddo_dimm_s d,
                                                 input logic [31:0] loc,
                                                 input ddo_pkg::ddo_req_s r);
        ddo_pkg::ddo_cmd_s c;
        logic [31:0]       a;
        logic [3:0]        rowW;
        logic [1:0]        bankW;
        c = '0;
        // Byte address within channel; 8-byte bus word selects the column
        a = loc << `DDO_LINE_OFS_W;
        rowW = (d.modType == `DDO_MOD_SS_X16) ? `DDO_ROW_X16 : `DDO_ROW_X8;
        bankW = d.gigabit ? `DDO_BANKS_1G : `DDO_BANKS_512M;
        c.col = a[12:3]; // 8K page across the 64-bit rank, see [RULE15]
        c.bank = (bankW == `DDO_BANKS_1G) ? a[15:13] : {1'b0, a[14:13]};
        if (bankW == `DDO_BANKS_1G) begin
            c.row = (rowW == `DDO_ROW_X16) ? {1'b0, a[28:16]} : a[29:16];
            c.rank = (d.modType == `DDO_MOD_DS_X8) ? a[30] : 1'b0;
        end else begin
            c.row = (rowW == `DDO_ROW_X16) ? {1'b0, a[27:15]} : a[28:15];
            c.rank = (d.modType == `DDO_MOD_DS_X8) ? a[29] : 1'b0;
        end
        c.write = r.write;
        c.tag = r.tag;
        return c;
    endfunction : decode

    // ----------------------------------------
    // Organization selection
    // ----------------------------------------
    ddo_pkg::ddo_dimm_s dimm0_ff;
    ddo_pkg::ddo_dimm_s dimm1_ff;
    logic [31:0]        cap0_ff;
    logic [31:0]        cap1_ff;
    logic               single1_ff;

    // Straps latched by a clocked load, never by the reset itself
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            org <= ddo_pkg::DDO_ORG_NONE;
            dimm0_ff <= '0;
            dimm1_ff <= '0;
            cap0_ff <= 32'h0;
            cap1_ff <= 32'h0;
            single1_ff <= 1'b0;
            rateIs800 <= 1'b0;
        end else if (clkEn && cfgLoad) begin
            dimm0_ff <= dimm0;
            dimm1_ff <= dimm1;
            cap0_ff <= dimmLines(dimm0);
            cap1_ff <= dimmLines(dimm1);
            single1_ff <= (dimmLines(dimm0) == 32'h0);
            rateIs800 <= rate800; // 800 when set, else 667, see [RULE12]
            if ((dimmLines(dimm0) != 32'h0) && (dimmLines(dimm1) != 32'h0)) begin
                if (dimmLines(dimm0) == dimmLines(dimm1)) begin
                    org <= ddo_pkg::DDO_ORG_SYM; // see [RULE9]
                end else begin
                    org <= ddo_pkg::DDO_ORG_ASYM; // see [RULE11]
                end
            end else if ((dimmLines(dimm0) != 32'h0) || (dimmLines(dimm1) != 32'h0)) begin
                org <= ddo_pkg::DDO_ORG_SINGLE; // see [RULE5]
            end else begin
                org <= ddo_pkg::DDO_ORG_NONE;
            end
        end
    end

    // ----------------------------------------
    // Steering
    // ----------------------------------------
    logic        tgtCh;
    logic [31:0] locLine;
    logic        inRange;
    logic [31:0] lineW;

    always_comb begin
        lineW = 32'(req.line);
        tgtCh = 1'b0;
        locLine = lineW;
        inRange = 1'b0;
        case (org)
            ddo_pkg::DDO_ORG_SINGLE: begin
                tgtCh = single1_ff; // see [RULE4]
                locLine = lineW;
                inRange = lineW < (single1_ff ? cap1_ff : cap0_ff);
            end
            ddo_pkg::DDO_ORG_SYM: begin
                tgtCh = lineW[0]; // see [RULE6] [RULE16]
                locLine = lineW >> 1;
                inRange = (lineW >> 1) < cap0_ff;
            end
            ddo_pkg::DDO_ORG_ASYM: begin
                tgtCh = lineW >= cap0_ff; // see [RULE10]
                locLine = (lineW >= cap0_ff) ? (lineW - cap0_ff) : lineW;
                inRange = lineW < (cap0_ff + cap1_ff);
            end
            default: begin
                tgtCh = 1'b0;
                locLine = lineW;
                inRange = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // Per-channel issue and tracking
    // ----------------------------------------
    ddo_pkg::ddo_chst_e chSt_ff [2];
    logic               take;
    logic [1:0]         cmdFree;

    // Each channel owns one outstanding line; the other stays free, see [RULE7] [RULE8]
    assign cmdFree[0] = (chSt_ff[0] == ddo_pkg::DDO_CH_IDLE) && !chCmdValid[0];
    assign cmdFree[1] = (chSt_ff[1] == ddo_pkg::DDO_CH_IDLE) && !chCmdValid[1];
    assign take = reqValid && reqReady;

    // Judged on the held request's own channel, so the opposite one takes a line
    // while the first is out; host holds valid and request until taken, see [RULE7] [RULE8]
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reqReady <= 1'b0;
        end else if (clkEn) begin
            reqReady <= reqValid && (org != ddo_pkg::DDO_ORG_NONE) && !take && (!inRange || cmdFree[tgtCh]);
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reqErr <= 1'b0;
        end else if (clkEn) begin
            reqErr <= take && !inRange;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            chCmdValid <= 2'b00;
            chCmd0 <= '0;
            chCmd1 <= '0;
        end else if (clkEn) begin
            for (int i = 0; i < 2; i++) begin
                if (chCmdValid[i] && chCmdReady[i]) begin
                    chCmdValid[i] <= 1'b0;
                end
            end
            if (take && inRange) begin
                chCmdValid[tgtCh] <= 1'b1; // 64-bit channel, see [RULE1] [RULE3]
                if (tgtCh) begin
                    chCmd1 <= decode(dimm1_ff, locLine, req); // see [RULE2] [RULE13]
                end else begin
                    chCmd0 <= decode(dimm0_ff, locLine, req);
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            chSt_ff[0] <= ddo_pkg::DDO_CH_IDLE;
            chSt_ff[1] <= ddo_pkg::DDO_CH_IDLE;
            chBusy <= 2'b00;
        end else if (clkEn) begin
            for (int i = 0; i < 2; i++) begin
                case (chSt_ff[i])
                    ddo_pkg::DDO_CH_IDLE: begin
                        if (take && inRange && (tgtCh == 1'(i))) begin
                            chSt_ff[i] <= ddo_pkg::DDO_CH_BUSY;
                            chBusy[i] <= 1'b1;
                        end
                    end
                    ddo_pkg::DDO_CH_BUSY: begin
                        if (chDone[i]) begin
                            chSt_ff[i] <= ddo_pkg::DDO_CH_DONE;
                        end
                    end
                    ddo_pkg::DDO_CH_DONE: begin
                        chSt_ff[i] <= ddo_pkg::DDO_CH_IDLE;
                        chBusy[i] <= 1'b0;
                    end
                    default: begin
                        chSt_ff[i] <= ddo_pkg::DDO_CH_IDLE;
                        chBusy[i] <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule : ddo_organizer

`default_nettype wire

// ---- tb/ddo_organizer_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module ddo_organizer_sva (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // Straps and host side
    input wire ddo_pkg::ddo_dimm_s dimm0,
    input wire ddo_pkg::ddo_dimm_s dimm1,
    input wire logic rate800,
    input wire logic cfgLoad,
    input wire logic reqValid,
    input wire ddo_pkg::ddo_req_s req,
    input wire logic reqReady,
    input wire logic reqErr,
    // Channel side and status
    input wire logic [1:0] chCmdValid,
    input wire ddo_pkg::ddo_cmd_s chCmd0,
    input wire ddo_pkg::ddo_org_e org,
    input wire logic rateIs800
);
    // ----------
    // Helpers
    // ----------
    // Capacity as a power of two in 256 MB steps; equal steps mean equal size
    function automatic logic [2:0] lg(ddo_pkg::ddo_dimm_s d);
        return {1'b0, d.modType} + {2'h0, d.gigabit};
    endfunction : lg
    logic        take, cfg, both, same, isSgl, isSym, isAsy;
    logic [25:0] cap0;
    assign take = reqValid && reqReady && clkEn;
    assign cfg = cfgLoad && clkEn;
    assign both = dimm0.present && dimm1.present;
    assign same = lg(dimm0) == lg(dimm1);
    assign isSgl = org == ddo_pkg::DDO_ORG_SINGLE;
    assign isSym = org == ddo_pkg::DDO_ORG_SYM;
    assign isAsy = org == ddo_pkg::DDO_ORG_ASYM;
    assign cap0 = 26'h40_0000 << lg(dimm0);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // ----------
    // Checks
    // ----------
    single_sel_a: assert property (cfg && dimm0.present != dimm1.present |=> isSgl)
        else $error("single org not chosen");
    sym_sel_a: assert property (cfg && both && same |=> isSym)
        else $error("symmetric org not chosen");
    asym_sel_a: assert property (cfg && both && !same |=> isAsy)
        else $error("asymmetric org not chosen");
    rate_cap_a: assert property (cfg |=> rateIs800 == $past(rate800))
        else $error("rate not captured");
    single_route_a: assert property (take && isSgl |=> reqErr || chCmdValid == {dimm1.present, dimm0.present})
        else $error("single steering wrong");
    sym_route_a: assert property (take && isSym |=> reqErr || chCmdValid == ($past(req.line[0]) ? 2'b10 : 2'b01))
        else $error("symmetric steering wrong");
    asym_route_a: assert property (take && isAsy |=> reqErr || chCmdValid == ($past(req.line) >= cap0 ? 2'b10 : 2'b01))
        else $error("asymmetric steering wrong");
    col_map_a: assert property (take && isSym && !req.line[0] |=> chCmd0.col == {$past(req.line[7:1]), 3'h0})
        else $error("column decode wrong");
    cover property (take && isSgl);
    cover property (take && isSym);
    cover property (take && isAsy ##1 reqErr);
    cover property (take && isSym ##2 take);
endmodule : ddo_organizer_sva
bind ddo_organizer ddo_organizer_sva u_sva (.*);
`default_nettype wire

// ---- tb/ddo_dimm_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ddo_dimm_model #(
    parameter int RDY_DLY  = 0,
    parameter int DONE_DLY = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Command handshake
    input wire logic cmdValid,
    input wire ddo_pkg::ddo_cmd_s cmd,
    output logic cmdReady,
    output logic done,
    // Last command taken
    output ddo_pkg::ddo_cmd_s lastCmd
);
    int waitCnt;
    int busyCnt;
    // Ready lags valid by RDY_DLY+1 cycles to model a stalling channel
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmdReady <= 1'b0;
            done <= 1'b0;
            waitCnt <= 0;
            busyCnt <= 0;
            lastCmd <= '0;
        end else begin
            done <= busyCnt == 1;
            waitCnt <= (cmdValid && !cmdReady) ? waitCnt + 1 : 0;
            if (busyCnt != 0) busyCnt <= busyCnt - 1;
            if (cmdValid && cmdReady) begin
                cmdReady <= 1'b0;
                lastCmd <= cmd;
                busyCnt <= DONE_DLY;
            end else if (cmdValid && waitCnt >= RDY_DLY) begin
                cmdReady <= 1'b1;
            end
        end
    end
endmodule : ddo_dimm_model
`default_nettype wire

// ---- tb/tb_ddo_organizer.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_ddo_organizer;
    logic core_clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1, rate800 = 1'b0, cfgLoad = 1'b0, reqValid = 1'b0;
    ddo_pkg::ddo_dimm_s dimm0 = '0, dimm1 = '0;
    ddo_pkg::ddo_req_s  req = '0;
    logic               reqReady, reqErr, rateIs800;
    logic [1:0]         chCmdValid, chCmdReady, chDone, chBusy;
    ddo_pkg::ddo_cmd_s  chCmd0, chCmd1, m0Cmd, m1Cmd;
    ddo_pkg::ddo_org_e  org;
    int                 error_cnt = 0, cmp_count = 0;
    always #5 core_clk = ~core_clk;
    ddo_organizer u_ddo_organizer (.*);
    // Channel 1 is the slow one, so the channels never run in lockstep
    ddo_dimm_model m0 (.clk(core_clk), .rst(sys_rst), .cmdValid(chCmdValid[0]), .cmd(chCmd0),
        .cmdReady(chCmdReady[0]), .done(chDone[0]), .lastCmd(m0Cmd));
    ddo_dimm_model #(.RDY_DLY(2), .DONE_DLY(6)) m1 (.clk(core_clk), .rst(sys_rst), .cmdValid(chCmdValid[1]),
        .cmd(chCmd1), .cmdReady(chCmdReady[1]), .done(chDone[1]), .lastCmd(m1Cmd));
    // ----------
    // Bus tasks
    // ----------
    task automatic cfg(input ddo_pkg::ddo_dimm_s a, input ddo_pkg::ddo_dimm_s b, input logic r);
        @(negedge core_clk);
        dimm0 = a;
        dimm1 = b;
        rate800 = r;
        cfgLoad = 1'b1;
        @(negedge core_clk);
        cfgLoad = 1'b0;
        @(negedge core_clk);
    endtask : cfg
    // Entered at a falling edge; returns at the falling edge after the taking edge
    task automatic put(input logic [25:0] ln);
        int k;
        k = 0;
        reqValid = 1'b1;
        req = {1'b0, ln, ln[3:0]};
        while (reqReady !== 1'b1 && k < 100) begin
            @(negedge core_clk);
            k++;
        end
        @(negedge core_clk);
    endtask : put
    // An expected mask of zero means the line must be refused
    task automatic issue(input logic [25:0] ln, input logic [1:0] exp);
        int k;
        k = 0;
        @(negedge core_clk);
        put(ln);
        reqValid = 1'b0;
        `CHK(chCmdValid, exp)
        `CHK(reqErr, exp == 2'b00)
        while (chBusy !== 2'b00 && k < 100) begin
            @(negedge core_clk);
            k++;
        end
        `CHK(chBusy, 2'b00)
    endtask : issue
    // ----------
    // Tests
    // ----------
    task automatic t_single;
        for (int i = 0; i < 2; i++) begin
            cfg(i ? 4'h0 : 4'h8, i ? 4'h8 : 4'h0, i[0]);
            `CHK(org, ddo_pkg::DDO_ORG_SINGLE)
            `CHK(rateIs800, i[0])
            issue(26'h9, i ? 2'b10 : 2'b01);
        end
        $display("t_single done");
    endtask : t_single
    task automatic t_sym;
        cfg(4'h9, 4'ha, 1'b1);
        `CHK(org, ddo_pkg::DDO_ORG_SYM)
        issue(26'h6, 2'b01);
        `CHK(m0Cmd.col, 10'h18)
        issue(26'h7, 2'b10);
        `CHK(m1Cmd.col, 10'h18)
        $display("t_sym done");
    endtask : t_sym
    task automatic t_asym;
        cfg(4'h8, 4'hb, 1'b0);
        `CHK(org, ddo_pkg::DDO_ORG_ASYM)
        issue(26'h3fffff, 2'b01);
        `CHK(m0Cmd.bank, 3'h3)
        `CHK(m0Cmd.row, 14'h1fff)
        `CHK(m0Cmd.col, 10'h3f8)
        issue(26'h400000, 2'b10);
        `CHK(m1Cmd.row, 14'h0)
        issue(26'h1400000, 2'b00);
        $display("t_asym done");
    endtask : t_asym
    // Two adjacent lines on double-sided modules: the second goes out while the first is busy
    task automatic t_overlap;
        cfg(4'hc, 4'hc, 1'b1);
        `CHK(org, ddo_pkg::DDO_ORG_SYM)
        @(negedge core_clk);
        put(26'h100_0000);
        put(26'h100_0001);
        reqValid = 1'b0;
        `CHK(chCmdValid, 2'b10)
        `CHK(chBusy, 2'b11)
        repeat (24) @(negedge core_clk);
        `CHK(chBusy, 2'b00)
        `CHK(m0Cmd.rank, 1'b1)
        `CHK(m1Cmd.rank, 1'b1)
        $display("t_overlap done");
    endtask : t_overlap
    task automatic print_verdict;
        $display("comparisons=%0d mismatches=%0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (20) @(negedge core_clk);
        sys_rst = 1'b0;
        t_single();
        t_sym();
        t_asym();
        t_overlap();
        print_verdict();
    end
    // The tests need well under a thousand cycles; this leaves ample margin
    initial begin
        #200us;
        error_cnt++;
        print_verdict();
    end
endmodule : tb_ddo_organizer
`default_nettype wire
